/* File: usb_endpoint_buffer_control.sv */
// Endpoint buffer command register and the handshake steering built on it.
// Behaviour
// - One byte command register, three reserved bits.
// - Clear bit empties selected endpoint buffer.
// - Fully read receive buffer empties itself.
// - Each clear empties one buffer only.
// - Validate bit marks IN data ready.
// - Full MaxPacketSize count validates automatically.
// - Data stage NAKed until data_stage_go set.
// - Data stage handshake clears data_stage_go.
// - data_stage_go reads back as zero.
// - Status ack zero NAKs, one answers.
// - Status ack self clears silently.
// - Status ack affects control endpoint only.
// - Stall bit stalls non-isochronous endpoint.
// - Re-enable reinitialises data toggle, stall not.
// - Index bits four to one select endpoint.
// - Index bit zero selects direction.
// - Index bit five selects setup buffer on endpoint zero only.
`default_nettype none
module usb_endpoint_buffer_control
  import ep_buf_ctrl_pkg::*;
(
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic usb_bus_reset_i,
  // Parallel register bus, same clock domain.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Selected endpoint view from the index register.
  input wire logic [7:0] endpoint_index_i,
  input wire logic [NUM_EP-1:0] ep_isochronous_i,
  input wire logic [NUM_EP-1:0] ep_enable_i,
  // Selected endpoint FIFO state.
  input wire logic [CNT_W-1:0] tx_byte_count_i,
  input wire logic [CNT_W-1:0] max_packet_size_i,
  input wire logic rx_last_byte_read_i,
  // Control transfer events from the serial engine.
  input wire logic setup_token_i,
  input wire logic data_out_acked_i,
  input wire logic data_in_acked_i,
  input wire logic status_done_i,
  // Buffer management commands.
  output logic buf_clear_o,
  output logic buf_validate_o,
  output logic [3:0] cmd_endpoint_o,
  output logic cmd_dir_o,
  output logic cmd_setup_buf_o,
  // Handshake steering toward the host.
  output logic data_stage_nak_o,
  output logic status_ack_o,
  output logic status_nak_o,
  output logic [NUM_EP-1:0] ep_stalled_tx_o,
  output logic [NUM_EP-1:0] ep_stalled_rx_o,
  output logic [NUM_EP-1:0] toggle_reset_o
);

  ////////////////////////////////////////////////////////////////////////////////
  logic cmd_wr;
  logic [3:0] sel_ep;
  logic sel_dir;
  logic data_stage_go_q;
  logic status_ack_q;
  logic buf_clear_q;
  logic buf_validate_q;
  logic [3:0] cmd_ep_q;
  logic cmd_dir_q;
  logic cmd_setup_q;
  logic [NUM_EP-1:0] stall_tx_q;
  logic [NUM_EP-1:0] stall_rx_q;
  logic [NUM_EP-1:0] ep_enable_q;
  logic [NUM_EP-1:0] toggle_reset_q;
  logic [7:0] rdata_q;
  logic auto_valid_armed_q;
  logic stall_rd;
  logic tx_full_now;
  logic clear_req;
  logic validate_req;
  logic enable_seen_q;

  ////////////////////////////////////////////////////////////////////////////////
  // True when the index points at the control endpoint.
  function automatic logic is_ctrl_ep(input logic [3:0] ep);
    return ep == 4'h0;
  endfunction

  // True when a transmit FIFO holds a whole packet of a nonzero size.
  function automatic logic tx_full(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] mps);
    return (mps != '0) && (cnt == mps);
  endfunction

  // Read-back image: reserved bits and the write-only data-stage bit read as zero.
  function automatic logic [7:0] cmd_image(input logic clr, input logic vld, input logic sts,
                                           input logic stl);
    return {3'b000, clr, vld, 1'b0, sts, stl} & CMD_READ_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Selection decode.
  // Endpoint selection field.
  assign sel_ep = endpoint_index_i[SEL_HI:SEL_LO];
  assign sel_dir = endpoint_index_i[DIR_BIT];
  // Commands decode only on the command offset.
  assign cmd_wr = clk_en_i && reg_wr_i && (reg_addr_i == CMD_REG_ADDR);
  // Stall flag of the selected endpoint and direction, shown on read-back.
  assign stall_rd = sel_dir ? stall_tx_q[sel_ep] : stall_rx_q[sel_ep];
  // A transmit FIFO that holds a whole packet on the selected IN endpoint.
  assign tx_full_now = sel_dir && tx_full(tx_byte_count_i, max_packet_size_i);
  // Clear on command; one buffer per pulse.
  // Auto clear after last byte read.
  assign clear_req = (cmd_wr && reg_wdata_i[CLEAR_BIT]) || (rx_last_byte_read_i && !sel_dir);
  // Explicit validate; auto validate at full count.
  assign validate_req = (cmd_wr && reg_wdata_i[VALIDATE_BIT] && sel_dir) ||
                        (tx_full_now && auto_valid_armed_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Latched target of the most recent command write.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cmd_ep_q <= 4'h0;
      cmd_dir_q <= 1'b0;
      cmd_setup_q <= 1'b0;
    end
    else if (clk_en_i && usb_bus_reset_i)
    begin
      cmd_ep_q <= 4'h0;
      cmd_dir_q <= 1'b0;
      cmd_setup_q <= 1'b0;
    end
    else if (cmd_wr)
    begin
      cmd_ep_q <= sel_ep;
      cmd_dir_q <= sel_dir;
      // Setup buffer only on endpoint zero.
      cmd_setup_q <= endpoint_index_i[SETUP_SEL_BIT] && is_ctrl_ep(sel_ep);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle clear and validate pulses.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      buf_clear_q <= 1'b0;
      buf_validate_q <= 1'b0;
      auto_valid_armed_q <= 1'b1;
    end
    else if (clk_en_i)
    begin
      if (usb_bus_reset_i)
      begin
        buf_clear_q <= 1'b0;
        buf_validate_q <= 1'b0;
        auto_valid_armed_q <= 1'b1;
      end
      else
      begin
        buf_clear_q <= clear_req;
        buf_validate_q <= validate_req;
        // The arm flag lets a full FIFO validate only once; it rearms when the
        // count moves away from the packet size.
        if (tx_full_now)
          auto_valid_armed_q <= 1'b0;
        else
          auto_valid_armed_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control transfer stage flags.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_stage_go_q <= 1'b0;
      status_ack_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (usb_bus_reset_i)
      begin
        data_stage_go_q <= 1'b0;
        status_ack_q <= 1'b0;
      end
      else
      begin
        // Firmware sets; handshake clears, set wins.
        if (cmd_wr && reg_wdata_i[DATA_STAGE_BIT])
          data_stage_go_q <= 1'b1;
        else if (data_out_acked_i || data_in_acked_i)
          data_stage_go_q <= 1'b0;
        // Self clear on status done or setup, no event raised.
        // A status write wins over a self clear in the same cycle.
        if (cmd_wr && is_ctrl_ep(sel_ep))
          status_ack_q <= reg_wdata_i[STATUS_ACK_BIT];
        else if (status_done_i || setup_token_i)
          status_ack_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Endpoint enable edges. The first enabled cycle after reset only records the
  // levels, so endpoints that come up enabled see no spurious toggle reset.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ep_enable_q <= '0;
      enable_seen_q <= 1'b0;
      toggle_reset_q <= '0;
    end
    else if (clk_en_i)
    begin
      ep_enable_q <= ep_enable_i;
      enable_seen_q <= 1'b1;
      // Toggle reset on rising enable only.
      if (enable_seen_q)
        toggle_reset_q <= ep_enable_i & ~ep_enable_q;
      else
        toggle_reset_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stall flags. Stalling leaves the data toggle alone.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stall_tx_q <= '0;
      stall_rx_q <= '0;
    end
    else if (clk_en_i)
    begin
      // A stall write to an isochronous endpoint leaves its flag unchanged.
      if (usb_bus_reset_i)
      begin
        stall_tx_q <= '0;
        stall_rx_q <= '0;
      end
      else if (cmd_wr && !ep_isochronous_i[sel_ep])
      begin
        if (sel_dir)
          stall_tx_q[sel_ep] <= reg_wdata_i[STALL_BIT];
        else
          stall_rx_q[sel_ep] <= reg_wdata_i[STALL_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read path.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_q <= CMD_RESET;
    else if (clk_en_i && reg_rd_i)
    begin
      // Reserved bits zero; data_stage_go reads zero.
      if (reg_addr_i == CMD_REG_ADDR)
        rdata_q <= cmd_image(buf_clear_q, buf_validate_q, status_ack_q, stall_rd);
      else
        rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign buf_clear_o = buf_clear_q;
  assign buf_validate_o = buf_validate_q;
  assign cmd_endpoint_o = cmd_ep_q;
  assign cmd_dir_o = cmd_dir_q;
  assign cmd_setup_buf_o = cmd_setup_q;
  assign data_stage_nak_o = !data_stage_go_q;
  // Answer or NAK status; control endpoint only.
  assign status_ack_o = status_ack_q;
  assign status_nak_o = !status_ack_q;
  assign ep_stalled_tx_o = stall_tx_q;
  assign ep_stalled_rx_o = stall_rx_q;
  assign toggle_reset_o = toggle_reset_q;

endmodule
`default_nettype wire

/* File: ep_buf_ctrl_pkg.sv */
// Package with register offsets, field positions and sizes of the endpoint buffer command block.
`default_nettype none
package ep_buf_ctrl_pkg;
  localparam logic [7:0] CMD_REG_ADDR = 8'h28;
  localparam logic [7:0] INDEX_REG_ADDR = 8'h2C;
  localparam int STALL_BIT = 0;
  localparam int STATUS_ACK_BIT = 1;
  localparam int DATA_STAGE_BIT = 2;
  localparam int VALIDATE_BIT = 3;
  localparam int CLEAR_BIT = 4;
  localparam int DIR_BIT = 0;
  localparam int SEL_LO = 1;
  localparam int SEL_HI = 4;
  localparam int SETUP_SEL_BIT = 5;
  localparam int NUM_EP = 16;
  localparam int CNT_W = 11;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_READ_MASK = 8'h1B;
endpackage
`default_nettype wire

/* File: ep_buf_ctrl_properties.sv */
// Port-level checks of the endpoint buffer command block.
`default_nettype none
module ep_buf_ctrl_chk
  import ep_buf_ctrl_pkg::*;
(
  // Clock, reset and register bus.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] endpoint_index_i,
  // Command and handshake outputs.
  input wire logic buf_clear_o,
  input wire logic buf_validate_o,
  input wire logic [3:0] cmd_endpoint_o,
  input wire logic cmd_dir_o,
  input wire logic data_stage_nak_o,
  input wire logic status_ack_o,
  input wire logic status_nak_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic w;
  logic [7:0] d;
  assign w = clk_en_i && reg_wr_i && reg_addr_i == CMD_REG_ADDR;
  assign d = reg_wdata_i;
  clear_pulse_a:
    assert property (w && d[4] |=> buf_clear_o) else $error("clear missed");
  validate_pulse_a:
    assert property (w && d[3] && endpoint_index_i[0] |=> buf_validate_o)
      else $error("validate missed");
  stage_go_a:
    assert property (w && d[2] |=> !data_stage_nak_o) else $error("stage nak kept");
  rsvd_read_a:
    assert property (reg_rdata_o[7:5] == 3'h0) else $error("reserved bits set");
  stage_read_a:
    assert property (!reg_rdata_o[2]) else $error("stage bit read");
  status_pair_a:
    assert property (status_ack_o != status_nak_o) else $error("status pair");
  status_set_a:
    assert property (w && d[1] && endpoint_index_i[4:1] == 4'h0 |=> status_ack_o)
      else $error("status not set");
  status_ep0_a:
    assert property (w && d[1] && endpoint_index_i[4:1] != 4'h0 && !status_ack_o
      |=> !status_ack_o) else $error("status on data ep");
  target_latch_a:
    assert property (w && d[4] |=> cmd_endpoint_o == $past(endpoint_index_i[4:1])
      && cmd_dir_o == $past(endpoint_index_i[0])) else $error("target not latched");
  cover property (w && d[0]);
  cover property (buf_validate_o && !$past(w));
  cover property (!data_stage_nak_o);
  cover property (status_ack_o);
endmodule
`default_nettype wire

/* File: ep_fifo_model.sv */
// Transmit FIFO byte counter that firmware fills for the selected endpoint.
`default_nettype none
module ep_fifo_model (
  // Clock, byte load and buffer commands.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic buf_clear_i,
  input wire logic buf_validate_i,
  // Byte count seen by the block.
  output logic [10:0] tx_byte_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A validated or cleared buffer restarts from zero.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i) tx_byte_count_o <= 11'h000;
    else if (buf_clear_i || buf_validate_i) tx_byte_count_o <= 11'h000;
    else if (load_i) tx_byte_count_o <= tx_byte_count_o + 11'h001;
endmodule
`default_nettype wire

/* File: tb.sv */
// Directed bench of the endpoint buffer command block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ep_buf_ctrl_pkg::*;
  logic sys_clk_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic clk_en_i = 1, usb_bus_reset_i = 0;
  logic [5:0] evt = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, endpoint_index_i = 0, reg_rdata_o;
  logic [15:0] ep_isochronous_i = 16'h0008, ep_enable_i = 16'hFFFF;
  logic [15:0] ep_stalled_tx_o, ep_stalled_rx_o, toggle_reset_o;
  logic [10:0] tx_byte_count_i;
  logic [3:0] cmd_endpoint_o;
  logic buf_clear_o, buf_validate_o, cmd_dir_o, cmd_setup_buf_o;
  logic data_stage_nak_o, status_ack_o, status_nak_o;
  int err_count = 0, checks = 0, vcnt = 0, ccnt = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    vcnt += buf_validate_o;
    ccnt += buf_clear_o;
  end
  usb_endpoint_buffer_control dut (.sys_clk_i, .rstn_i, .clk_en_i,
    .usb_bus_reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .endpoint_index_i, .ep_isochronous_i, .ep_enable_i,
    .tx_byte_count_i, .max_packet_size_i(11'h004), .rx_last_byte_read_i(evt[4]),
    .setup_token_i(evt[0]), .data_out_acked_i(evt[1]), .data_in_acked_i(evt[2]),
    .status_done_i(evt[3]), .buf_clear_o, .buf_validate_o, .cmd_endpoint_o,
    .cmd_dir_o, .cmd_setup_buf_o, .data_stage_nak_o, .status_ack_o, .status_nak_o,
    .ep_stalled_tx_o, .ep_stalled_rx_o, .toggle_reset_o);
  ep_fifo_model fifo (.sys_clk_i, .rstn_i, .load_i(evt[5]), .buf_clear_i(buf_clear_o),
    .buf_validate_i(buf_validate_o), .tx_byte_count_o(tx_byte_count_i));
  task tk;
    @(posedge sys_clk_i);
    #1;
  endtask
  task ck(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    tk;
    // Selection settles a cycle before the command write.
    endpoint_index_i = i;
    tk;
    reg_addr_i = CMD_REG_ADDR;
    reg_wdata_i = d;
    reg_wr_i = 1;
    tk;
    reg_wr_i = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    tk;
    reg_addr_i = a;
    reg_rd_i = 1;
    tk;
    reg_rd_i = 0;
    tk;
    ck("rdata", e, reg_rdata_o);
  endtask
  task ev(input logic [5:0] m);
    evt = m;
    tk;
    evt = 0;
    tk;
  endtask
  task wrap_up;
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    wrap_up;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk_i);
    #1 rstn_i = 1;
    ck("stage_nak", 1, data_stage_nak_o);
    ck("status_nak", 1, status_nak_o);
    tk;
    ck("toggle", 0, toggle_reset_o);
    wr(8'h0B, 8'h10);
    endpoint_index_i = 8'h02;
    tk;
    ck("cmd_ep", 5, cmd_endpoint_o);
    ck("cmd_dir", 1, cmd_dir_o);
    wr(8'h0B, 8'h10);
    tk;
    ck("clears", 2, ccnt);
    wr(8'h0A, 8'h08);
    wr(8'h0B, 8'h08);
    tk;
    ck("validates", 1, vcnt);
    endpoint_index_i = 8'h03;
    repeat (4) ev(6'h20);
    repeat (3) tk;
    ck("auto_val", 2, vcnt);
    endpoint_index_i = 8'h02;
    ev(6'h10);
    ck("auto_clr", 3, ccnt);
    clk_en_i = 0;
    wr(8'h00, 8'h04);
    clk_en_i = 1;
    ck("stage_nak", 1, data_stage_nak_o);
    wr(8'h00, 8'h04);
    ck("stage_nak", 0, data_stage_nak_o);
    rd(CMD_REG_ADDR, 8'h00);
    ev(6'h02);
    ck("stage_nak", 1, data_stage_nak_o);
    wr(8'h01, 8'h04);
    ev(6'h04);
    ck("stage_nak", 1, data_stage_nak_o);
    wr(8'h00, 8'h02);
    ck("status_ack", 1, status_ack_o);
    rd(CMD_REG_ADDR, 8'h02);
    ev(6'h08);
    ck("status_ack", 0, status_ack_o);
    wr(8'h01, 8'h02);
    ev(6'h01);
    ck("status_ack", 0, status_ack_o);
    wr(8'h02, 8'h02);
    ck("status_ack", 0, status_ack_o);
    wr(8'h00, 8'h02);
    wr(8'h02, 8'h02);
    ck("status_ack", 1, status_ack_o);
    usb_bus_reset_i = 1;
    tk;
    usb_bus_reset_i = 0;
    ck("status_nak", 1, status_nak_o);
    wr(8'h05, 8'h01);
    rd(CMD_REG_ADDR, 8'h01);
    wr(8'h06, 8'h01);
    ck("stall_rx", 0, ep_stalled_rx_o);
    wr(8'h1F, 8'h01);
    ck("stall_tx", 16'h8004, ep_stalled_tx_o);
    ep_enable_i = 16'hFFFB;
    tk;
    tk;
    ep_enable_i = 16'hFFFF;
    tk;
    ck("toggle", 16'h0004, toggle_reset_o);
    ck("stall_tx", 16'h8004, ep_stalled_tx_o);
    wr(8'h20, 8'h10);
    ck("setup_buf", 1, cmd_setup_buf_o);
    wr(8'h22, 8'h10);
    ck("setup_buf", 0, cmd_setup_buf_o);
    rd(8'h2A, 8'h00);
    wrap_up;
  end
endmodule
bind usb_endpoint_buffer_control ep_buf_ctrl_chk chk (.sys_clk_i, .rstn_i, .clk_en_i,
  .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .endpoint_index_i, .buf_clear_o,
  .buf_validate_o, .cmd_endpoint_o, .cmd_dir_o, .data_stage_nak_o, .status_ack_o,
  .status_nak_o);
`default_nettype wire
